// [rtl/urx_cfg.svh]
// register offsets, field positions and reset values of the receive channel
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

// ==========================================================================
// register byte offsets
`define URX_OFS_DATA 8'h00
`define URX_OFS_STATUS 8'h04
`define URX_OFS_FLAG_CLR 8'h08
`define URX_OFS_MODE 8'h0c
`define URX_OFS_EN_STAT 8'h10
`define URX_OFS_START 8'h14
`define URX_OFS_STOP 8'h18
`define URX_OFS_IRQ_STAT 8'h1c
`define URX_OFS_IRQ_MASK 8'h20

// ==========================================================================
// field positions
`define URX_DIV_LSB 9
`define URX_DIV_MSB 15
`define URX_ST_OVF 0
`define URX_ST_PEF 1
`define URX_ST_FEF 2
`define URX_ST_BFF 5
`define URX_MD_DLEN 0
`define URX_MD_PAR_LSB 1
`define URX_MD_PAR_MSB 2
`define URX_MD_STOP2 3
`define URX_MD_PRS_LSB 4
`define URX_MD_PRS_MSB 7
`define URX_CH_RX 1
`define URX_IRQ_DONE 0
`define URX_IRQ_ERR 1

// ==========================================================================
// reset values
`define URX_DIV_RST 7'h67
`define URX_MODE_RST 8'h01
`define URX_EN_RST 2'h0
`define URX_MASK_RST 2'h0

`endif

// [rtl/urx_pkg.sv]
// types shared by the receive channel files
package urx_pkg;
    // receiver sequencer states, gray along idle, start, bits
    typedef enum logic [1:0]
    {
        URX_IDLE = 2'b00,
        URX_START = 2'b01,
        URX_BITS = 2'b11
    } urx_state_t;

    // parity selection field
    typedef enum logic [1:0]
    {
        URX_PAR_NONE = 2'b00,
        URX_PAR_EVEN = 2'b01,
        URX_PAR_ODD = 2'b10,
        URX_PAR_OFF = 2'b11
    } urx_par_t;
endpackage

// [rtl/urx_bit_timer.sv]
// operation clock prescaler and half-bit tick generator
`timescale 1ns/10ps
module urx_bit_timer
    import urx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic [3:0] prs,
    input wire logic [6:0] div,
    input wire logic restart,
    input wire logic run,
    // tick out
    output logic half_tick
);
    logic [14:0] pre_cnt_reg;
    logic [14:0] pre_mask;
    logic mck_tick;
    logic [6:0] half_cnt_reg;

    // ======================================================================
    // prescaler: operation clock is clock over 2 to the power prs
    assign pre_mask = 15'((16'h0001 << prs) - 16'h0001);
    assign mck_tick = ((pre_cnt_reg & pre_mask) == pre_mask);

    // prescaler restarts with the start edge so the half bit is aligned
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pre_cnt_reg <= 15'h0000;
        else if (restart || !run)
            pre_cnt_reg <= 15'h0000;
        else
            pre_cnt_reg <= pre_cnt_reg + 15'h0001;
    end

    // ======================================================================
    // half bit of k clocks
    // k = div + 1 operation clocks per half bit, two halves per bit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_cnt_reg <= 7'h00;
            half_tick <= 1'b0;
        end
        else if (restart || !run)
        begin
            half_cnt_reg <= 7'h00;
            half_tick <= 1'b0;
        end
        else if (mck_tick && half_cnt_reg == div)
        begin
            half_cnt_reg <= 7'h00;
            half_tick <= 1'b1;
        end
        else
        begin
            half_cnt_reg <= mck_tick ? half_cnt_reg + 7'h01 : half_cnt_reg;
            half_tick <= 1'b0;
        end
    end

    // ======================================================================
    // checks
    chk_tick_spacing: assert property (@(posedge clock) disable iff (!rst_n)
        (half_tick && run && !restart && div >= 7'h02) |=> !half_tick [*2])
        else $error("half-bit ticks closer than three clocks");
endmodule

// [rtl/urx_top.sv]
// asynchronous serial receive channel with error flags, behind an ahb-lite slave
`timescale 1ns/10ps
`include "urx_cfg.svh"
module urx_top
    import urx_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // serial line
    input wire logic rxd,
    // interrupt
    output logic irq
);
    // ======================================================================
    // declarations
    logic pend_reg;
    logic pend_write_reg;
    logic pend_hit_reg;
    logic [7:0] pend_addr_reg;
    logic wr;
    logic rd;
    logic [31:0] rdata_next;
    logic [6:0] div_reg;
    logic [7:0] mode_reg;
    logic [1:0] en_reg;
    logic [2:0] err_reg;
    logic [2:0] err_set;
    logic bff_reg;
    logic [7:0] rx_data_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_set;
    urx_state_t state_reg;
    logic [3:0] bit_idx_reg;
    logic phase_reg;
    logic [7:0] shreg;
    logic par_acc_reg;
    logic stop_bad_reg;
    logic rxd_prev_reg;
    logic done_reg;
    logic done_pe_reg;
    logic done_fe_reg;
    logic half_tick;
    logic start_edge;
    logic sample;
    logic rx_run;
    logic [3:0] dlen;
    logic par_on;
    urx_par_t par_mode;
    logic [3:0] frame_bits;
    logic is_data;
    logic is_par;
    logic last_bit;
    logic stop_now_bad;
    logic go_pulse;
    logic halt_pulse;
    logic rd_data;
    logic clr_pulse;

    // ======================================================================
    // ahb-lite slave: one wait state on every transfer
    // taking the access a cycle late lets hrdata come from a flop
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_reg <= 1'b0;
            pend_write_reg <= 1'b0;
            pend_hit_reg <= 1'b0;
            pend_addr_reg <= 8'h00;
            hreadyout <= 1'b1;
        end
        else if (hsel && htrans[1] && hready && !pend_reg)
        begin
            pend_reg <= 1'b1;
            pend_write_reg <= hwrite;
            pend_hit_reg <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0)
                && (hsize == 3'h2);
            pend_addr_reg <= haddr[7:0];
            hreadyout <= 1'b0;
        end
        else
        begin
            pend_reg <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    // response is always okay
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    // strobes of the wait cycle; unmapped accesses do nothing
    assign wr = pend_reg && pend_write_reg && pend_hit_reg;
    assign rd = pend_reg && !pend_write_reg && pend_hit_reg;
    assign rd_data = rd && (pend_addr_reg == `URX_OFS_DATA);
    assign clr_pulse = wr && (pend_addr_reg == `URX_OFS_FLAG_CLR);
    assign go_pulse = wr && (pend_addr_reg == `URX_OFS_START) && hwdata[`URX_CH_RX];
    assign halt_pulse = wr && (pend_addr_reg == `URX_OFS_STOP) && hwdata[`URX_CH_RX];

    // read mux, reserved bits as zero
    always_comb
    begin
        rdata_next = 32'h00000000;
        if (pend_hit_reg)
        begin
            unique case (pend_addr_reg)
                `URX_OFS_DATA:
                    rdata_next = {16'h0000, div_reg, 1'b0, rx_data_reg};
                `URX_OFS_STATUS:
                    rdata_next = {26'h0000000, bff_reg, 2'b00, err_reg};
                `URX_OFS_MODE:
                    rdata_next = {24'h000000, mode_reg};
                `URX_OFS_EN_STAT:
                    rdata_next = {30'h00000000, en_reg};
                `URX_OFS_IRQ_STAT:
                    rdata_next = {30'h00000000, irq_st_reg};
                `URX_OFS_IRQ_MASK:
                    rdata_next = {30'h00000000, irq_mask_reg};
                default:
                    rdata_next = 32'h00000000;
            endcase
        end
    end

    // read data held until the next read
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= 32'h00000000;
        else if (pend_reg && !pend_write_reg)
            hrdata <= rdata_next;
    end

    // ======================================================================
    // configuration registers
    // divisor reset keeps k above two
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= `URX_DIV_RST;
            mode_reg <= `URX_MODE_RST;
            irq_mask_reg <= `URX_MASK_RST;
        end
        else if (wr)
        begin
            if (pend_addr_reg == `URX_OFS_DATA)
                div_reg <= hwdata[`URX_DIV_MSB:`URX_DIV_LSB];
            if (pend_addr_reg == `URX_OFS_MODE)
                mode_reg <= hwdata[7:0];
            if (pend_addr_reg == `URX_OFS_IRQ_MASK)
                irq_mask_reg <= hwdata[1:0];
        end
    end

    // ======================================================================
    // channel enable status, stop wins over start in one write pair
    // stop clears enable
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            en_reg <= `URX_EN_RST;
        else if (wr && pend_addr_reg == `URX_OFS_STOP)
            en_reg <= en_reg & ~hwdata[1:0];
        else if (wr && pend_addr_reg == `URX_OFS_START)
            en_reg <= en_reg | hwdata[1:0];
    end

    assign rx_run = en_reg[`URX_CH_RX];

    // ======================================================================
    // frame format decode
    // frame bits from format
    assign dlen = mode_reg[`URX_MD_DLEN] ? 4'h8 : 4'h7;
    assign par_mode = urx_par_t'(mode_reg[`URX_MD_PAR_MSB:`URX_MD_PAR_LSB]);
    assign par_on = (par_mode == URX_PAR_EVEN) || (par_mode == URX_PAR_ODD);
    assign frame_bits = 4'h1 + dlen + {3'h0, par_on} + (mode_reg[`URX_MD_STOP2] ? 4'h2 : 4'h1);

    // ======================================================================
    // half-bit timer
    urx_bit_timer u_timer
    (
        .clock(clock),
        .rst_n(rst_n),
        .prs(mode_reg[`URX_MD_PRS_MSB:`URX_MD_PRS_LSB]),
        .div(div_reg),
        .restart(start_edge),
        .run(state_reg != URX_IDLE),
        .half_tick(half_tick)
    );

    // ======================================================================
    // sampling decode of the current bit
    assign start_edge = (state_reg == URX_IDLE) && rx_run && rxd_prev_reg && !rxd;
    assign sample = (state_reg == URX_BITS) && half_tick && phase_reg;
    assign is_data = (bit_idx_reg <= dlen);
    assign is_par = par_on && (bit_idx_reg == dlen + 4'h1);
    assign last_bit = (bit_idx_reg == frame_bits - 4'h1);
    assign stop_now_bad = stop_bad_reg || (!is_data && !is_par && !rxd);

    // line history for the falling start edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rxd_prev_reg <= 1'b1;
        else
            rxd_prev_reg <= rxd;
    end

    // ======================================================================
    // receive sequencer
    // centre sampling bounds fast rate
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= URX_IDLE;
            bit_idx_reg <= 4'h0;
            phase_reg <= 1'b0;
        end
        else if (!rx_run)
            state_reg <= URX_IDLE;
        else
        begin
            unique case (state_reg)
                URX_IDLE:
                    if (start_edge)
                        state_reg <= URX_START;
                URX_START:
                    // mid start bit: a high line was a glitch
                    if (half_tick)
                    begin
                        state_reg <= rxd ? URX_IDLE : URX_BITS;
                        bit_idx_reg <= 4'h1;
                        phase_reg <= 1'b0;
                    end
                URX_BITS:
                    if (half_tick)
                    begin
                        phase_reg <= !phase_reg;
                        if (phase_reg)
                        begin
                            bit_idx_reg <= bit_idx_reg + 4'h1;
                            if (last_bit)
                                state_reg <= URX_IDLE;
                        end
                    end
                default:
                    state_reg <= URX_IDLE;
            endcase
        end
    end

    // data shift, parity accumulate and stop check
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shreg <= 8'h00;
            par_acc_reg <= 1'b0;
            stop_bad_reg <= 1'b0;
        end
        else if (start_edge)
        begin
            shreg <= 8'h00;
            par_acc_reg <= 1'b0;
            stop_bad_reg <= 1'b0;
        end
        else if (sample)
        begin
            if (is_data)
            begin
                shreg[3'(bit_idx_reg - 4'h1)] <= rxd;
                par_acc_reg <= par_acc_reg ^ rxd;
            end
            else if (is_par)
                par_acc_reg <= par_acc_reg ^ rxd; // received parity joins the sum
            stop_bad_reg <= stop_now_bad;
        end
    end

    // one-cycle completion pulse with its verdicts
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_reg <= 1'b0;
            done_pe_reg <= 1'b0;
            done_fe_reg <= 1'b0;
        end
        else
        begin
            done_reg <= sample && last_bit;
            done_pe_reg <= sample && last_bit && par_on
                && (par_acc_reg != (par_mode == URX_PAR_ODD));
            done_fe_reg <= sample && last_bit && stop_now_bad;
        end
    end

    // ======================================================================
    // receive buffer; an overrun still takes the newest character
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rx_data_reg <= 8'h00;
        else if (done_reg)
            rx_data_reg <= shreg;
    end

    // data read clears full
    // a character landing in the same cycle keeps the flag set
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            bff_reg <= 1'b0;
        else if (done_reg)
            bff_reg <= 1'b1;
        else if (rd_data)
            bff_reg <= 1'b0;
    end

    // ======================================================================
    // sticky error flags
    assign err_set[`URX_ST_OVF] = done_reg && bff_reg && !rd_data;
    assign err_set[`URX_ST_PEF] = done_pe_reg;
    assign err_set[`URX_ST_FEF] = done_fe_reg;

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_err
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    err_reg[i] <= 1'b0;
                else if (err_set[i])
                    err_reg[i] <= 1'b1;
                else if (clr_pulse && hwdata[i])
                    err_reg[i] <= 1'b0;
            end
        end
    endgenerate

    // ======================================================================
    // interrupt status, mask and level output
    assign irq_set[`URX_IRQ_DONE] = done_reg;
    assign irq_set[`URX_IRQ_ERR] = |err_set;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            irq_st_reg <= 2'h0;
        else if (wr && pend_addr_reg == `URX_OFS_IRQ_STAT)
            irq_st_reg <= irq_set | (irq_st_reg & ~hwdata[1:0]);
        else
            irq_st_reg <= irq_st_reg | irq_set;
    end

    // output flop adds one cycle behind the status bit
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_st_reg & irq_mask_reg);
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_bff_set: assert property (done_reg |=> bff_reg)
        else $error("full flag not set after a character");
    chk_bff_read_clear: assert property ((rd_data && !done_reg) |=> !bff_reg)
        else $error("data read did not clear full flag");
    chk_ovf_on_full: assert property ((done_reg && bff_reg && !rd_data) |=> err_reg[0])
        else $error("overrun not flagged");
    chk_fef_on_stop: assert property ((sample && last_bit && stop_now_bad) |=>
        ##1 err_reg[2])
        else $error("framing error not flagged");
    chk_flag_clear: assert property ((clr_pulse && hwdata[1] && !err_set[1]) |=>
        !err_reg[1])
        else $error("parity flag not cleared by a one");
    chk_flag_hold: assert property ((err_reg[2] && !(clr_pulse && hwdata[2])) |=>
        err_reg[2])
        else $error("framing flag dropped without a clear");
    chk_stop_halts: assert property (halt_pulse |=>
        !en_reg[1] ##1 (state_reg == URX_IDLE))
        else $error("stop trigger did not halt the channel");
    chk_start_runs: assert property ((go_pulse && !halt_pulse) |=> en_reg[1])
        else $error("start trigger did not enable the channel");
    // expected last index worked from the raw mode bits, not from frame_bits
    chk_frame_len: assert property ((sample && last_bit) |-> bit_idx_reg ==
        (mode_reg[`URX_MD_DLEN] ? 4'h9 : 4'h8)
        + {3'h0, ^mode_reg[`URX_MD_PAR_MSB:`URX_MD_PAR_LSB]} + {3'h0, mode_reg[`URX_MD_STOP2]})
        else $error("frame ended at the wrong bit count");
    chk_latch_tick: assert property (sample |-> half_tick && $past(half_tick, 1) == 1'b0)
        else $error("latch point off the half-bit grid");

    cov_good_frame: cover property (done_reg && !done_fe_reg && !done_pe_reg);
    cov_overrun: cover property (done_reg && bff_reg);
    cov_framing: cover property (done_fe_reg);
    cov_restart: cover property (halt_pulse ##[1:200] go_pulse);
endmodule

// [sim/urx_tx_model.sv]
// remote serial transmitter model that drives the receive line
`timescale 1ns/10ps
module urx_tx_model
(
    // clock
    input wire logic clock,
    // serial line
    output logic rxd
);
    // line rests high between frames, like a pulled-up idle line
    initial rxd = 1'b1;

    // ==========================================================================
    // frame sender
    // one frame lsb first: start, data, optional parity, stop bits
    // per is clocks per bit; off-nominal values probe the rate window
    // rate kept inside window
    task automatic send(input int per, input logic [7:0] d, input int nb, input int par,
        input logic bad_par, input int nst, input logic bad_stop);
        logic q[$];
        logic p;
        q = {1'b0};
        for (int i = 0; i < nb; i++) q.push_back(d[i]);
        // parity over the sent bits only, odd mode inverts
        p = (^(d & ((nb == 8) ? 8'hff : 8'h7f))) ^ (par == 2) ^ bad_par;
        if (par != 0) q.push_back(p);
        for (int i = 1; i < nst; i++) q.push_back(1'b1);
        // a bad stop drives only the last stop bit low
        q.push_back(!bad_stop);
        foreach (q[i])
        begin
            rxd <= q[i];
            repeat (per) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask
endmodule

// [sim/urx_top_bench.sv]
// self-checking bench for the receive channel and its error recovery
`timescale 1ns/10ps
`include "urx_cfg.svh"
module urx_top_bench;
    // clock, reset and bus drive
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic rxd;
    logic irq;
    logic [31:0] rv;
    int n_fail = 0;
    int checked = 0;
    int pers[2] = '{200, 217};
    logic [7:0] dats[2] = '{8'h3c, 8'hc3};

    // ==========================================================================
    // instances
    urx_top urx_top_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rxd(rxd), .irq(irq));
    urx_tx_model urx_tx_model_inst (.clock(clock), .rxd(rxd));

    // 100 mhz clock
    initial
    begin
        forever #5 clock = ~clock;
    end

    // ==========================================================================
    // bus and check tasks
    // one single transfer; waits on hready, the only bound is the watchdog
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rv = hrdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rv);
    endtask

    // send a frame, then leave room for flags and the irq lag
    task automatic rx(input int per, input logic [7:0] d, input int nb, input int par,
        input logic bp, input int ns, input logic bs);
        urx_tx_model_inst.send(per, d, nb, par, bp, ns, bs);
        repeat (6) @(posedge clock);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================================
    // test sequence
    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        // reset state, unmapped place, halted channel ignores the line
        rdc(`URX_OFS_DATA, 32'hce00, "divisor");
        rdc(`URX_OFS_EN_STAT, 32'h0, "enable");
        rdc(8'h40, 32'h0, "unmapped");
        chk("hresp", 32'h0, {31'h0, hresp});
        rx(208, 8'ha5, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_STATUS, 32'h0, "halted");
        bus(1'b1, `URX_OFS_START, 32'h2);
        rdc(`URX_OFS_EN_STAT, 32'h2, "started");
        $display("test reset done");
        // edges of the rate window at the reset divisor, 8n1
        foreach (pers[i])
        begin
            rx(pers[i], dats[i], 8, 0, 1'b0, 1, 1'b0);
            rdc(`URX_OFS_STATUS, 32'h20, "full");
            rdc(`URX_OFS_DATA, {16'h0, 8'hce, dats[i]}, "data");
            rdc(`URX_OFS_STATUS, 32'h0, "emptied");
        end
        bus(1'b1, `URX_OFS_DATA, 32'h400);
        rdc(`URX_OFS_DATA, 32'h4c3, "newdiv");
        $display("test tolerance done");
        // even and odd parity, good and bad
        for (int p = 1; p < 3; p++)
        begin
            bus(1'b1, `URX_OFS_MODE, 32'(p * 2 + 1));
            for (int b = 0; b < 2; b++)
            begin
                rx(6, 8'h96, 8, p, b[0], 1, 1'b0);
                rdc(`URX_OFS_DATA, 32'h496, "pdata");
                rdc(`URX_OFS_STATUS, 32'(b * 2), "perr");
                bus(1'b1, `URX_OFS_FLAG_CLR, rv);
                rdc(`URX_OFS_STATUS, 32'h0, "pclr");
            end
        end
        $display("test parity done");
        // overrun: second frame lands on a full buffer
        bus(1'b1, `URX_OFS_MODE, 32'h1);
        rx(6, 8'h11, 8, 0, 1'b0, 1, 1'b0);
        rx(6, 8'h22, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_STATUS, 32'h21, "ovr");
        rdc(`URX_OFS_DATA, 32'h422, "odata");
        rdc(`URX_OFS_STATUS, 32'h1, "ovr_held");
        bus(1'b1, `URX_OFS_FLAG_CLR, 32'h0);
        rdc(`URX_OFS_STATUS, 32'h1, "zero_clr");
        bus(1'b1, `URX_OFS_FLAG_CLR, rv);
        rdc(`URX_OFS_STATUS, 32'h0, "oclr");
        $display("test overrun done");
        // framing error, then stop, resync and restart
        rx(6, 8'h5a, 8, 0, 1'b0, 1, 1'b1);
        rdc(`URX_OFS_DATA, 32'h45a, "fdata");
        rdc(`URX_OFS_STATUS, 32'h4, "ferr");
        bus(1'b1, `URX_OFS_FLAG_CLR, rv);
        rdc(`URX_OFS_STATUS, 32'h0, "fclr");
        bus(1'b1, `URX_OFS_STOP, 32'h2);
        rdc(`URX_OFS_EN_STAT, 32'h0, "stopped");
        rx(6, 8'h77, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_STATUS, 32'h0, "ignored");
        bus(1'b1, `URX_OFS_START, 32'h2);
        rdc(`URX_OFS_EN_STAT, 32'h2, "restart");
        rx(6, 8'h78, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_DATA, 32'h478, "rdata");
        $display("test framing done");
        // seven data bits with two stop bits; second stop low
        bus(1'b1, `URX_OFS_MODE, 32'h8);
        rx(6, 8'hd5, 7, 0, 1'b0, 2, 1'b0);
        rdc(`URX_OFS_DATA, 32'h455, "d7");
        rdc(`URX_OFS_STATUS, 32'h0, "s7");
        rx(6, 8'h2a, 7, 0, 1'b0, 2, 1'b1);
        rdc(`URX_OFS_DATA, 32'h42a, "d7b");
        rdc(`URX_OFS_STATUS, 32'h4, "stop2");
        bus(1'b1, `URX_OFS_FLAG_CLR, rv);
        // prescaler of two: twelve clocks a bit at the same divisor
        bus(1'b1, `URX_OFS_MODE, 32'h11);
        rx(12, 8'h69, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_DATA, 32'h469, "prs_data");
        $display("test format done");
        // interrupt raised, masked and cleared
        bus(1'b1, `URX_OFS_MODE, 32'h1);
        bus(1'b1, `URX_OFS_IRQ_STAT, 32'h3);
        bus(1'b1, `URX_OFS_IRQ_MASK, 32'h1);
        rdc(`URX_OFS_IRQ_MASK, 32'h1, "mask");
        rx(6, 8'h0f, 8, 0, 1'b0, 1, 1'b0);
        chk("irq_on", 32'h1, {31'h0, irq});
        rdc(`URX_OFS_IRQ_STAT, 32'h1, "istat");
        bus(1'b1, `URX_OFS_IRQ_MASK, 32'h0);
        @(posedge clock);
        chk("irq_masked", 32'h0, {31'h0, irq});
        bus(1'b1, `URX_OFS_IRQ_MASK, 32'h1);
        @(posedge clock);
        chk("irq_again", 32'h1, {31'h0, irq});
        bus(1'b1, `URX_OFS_IRQ_STAT, 32'h1);
        rdc(`URX_OFS_IRQ_STAT, 32'h0, "iclr");
        chk("irq_off", 32'h0, {31'h0, irq});
        // error interrupt: a frame onto the still full buffer overruns
        bus(1'b1, `URX_OFS_IRQ_MASK, 32'h2);
        rx(6, 8'hf0, 8, 0, 1'b0, 1, 1'b0);
        rdc(`URX_OFS_IRQ_STAT, 32'h3, "ierr");
        chk("irq_err", 32'h1, {31'h0, irq});
        $display("test interrupt done");
        report_and_stop();
    end

    // watchdog, about four times the expected run
    initial
    begin
        repeat (30000) @(posedge clock);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
